// ### dv/ssp_checker_sva.sv
// assertion checker for the synchronous serial port
`timescale 1ns/10ps
`default_nettype none
module ssp_checker
   import ssp_pkg::*;
(
   input wire logic                  mclk_in,
   input wire logic                  reset_n_in,
   input wire logic                  enable_in,
   input wire logic                  master_mode_in,
   input wire logic                  sequential_in,
   input wire logic [NUM_SLAVES-1:0] profile_fsync_in,
   input wire logic [7:0]            prescale_in,
   input wire logic [7:0]            rate_in,
   input wire logic [WORD_W-1:0]     rx_data_out,
   input wire logic                  rx_valid_out,
   input wire logic                  rx_ready_in,
   input wire logic [2:0]            irq_mask_in,
   input wire logic [2:0]            irq_status_out,
   input wire logic                  combined_irq_out,
   input wire logic                  sclk_out,
   input wire logic                  sclk_oe_out,
   input wire logic [NUM_SLAVES-1:0] chip_select_line_out,
   input wire logic [NUM_SLAVES-1:0] chip_select_line_oe_out,
   input wire logic                  sdo_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   wire logic hot = |(irq_status_out & ~irq_mask_in);
   // rate checks only hold for the divider setting the bench uses
   wire logic fast = prescale_in == 8'h01 && rate_in == 8'h01;
   wire logic spi0 = master_mode_in && !profile_fsync_in[0] && !sequential_in;
   wire logic cs0 = chip_select_line_out[0];
   oe_master_a: assert property (master_mode_in && enable_in |=> sclk_oe_out)
      else $error("serial clock not driven in master mode");
   oe_slave_a: assert property (!master_mode_in |=> !sclk_oe_out && !chip_select_line_oe_out)
      else $error("pins driven in slave mode");
   irq_on_a: assert property (hot ##1 (hot && $stable(irq_mask_in)) |-> combined_irq_out)
      else $error("combined interrupt missing");
   irq_off_a: assert property (!hot ##1 (!hot && $stable(irq_mask_in)) |-> !combined_irq_out)
      else $error("masked source raised interrupt");
   spi_select_a: assert property ($rose(sclk_out) && spi0 |-> !cs0)
      else $error("clock edge without low select");
   sclk_rate_a: assert property ($rose(sclk_out) && fast |-> sclk_out [*4] ##1 !sclk_out)
      else $error("serial clock half period wrong");
   sdo_hold_a: assert property ($rose(sclk_out) && fast |=> $stable(sdo_out) [*3])
      else $error("data changed while clock high");
   rx_hold_a: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
      else $error("receive word lost before pop");
   fsync_pulse_a: assert property ($rose(cs0) && master_mode_in && profile_fsync_in[0] && fast
      |-> cs0 [*8] ##1 !cs0)
      else $error("frame sync pulse not one bit wide");
   cover property ($rose(combined_irq_out));
   cover property ($rose(cs0) && profile_fsync_in[0]);
   cover property (irq_status_out[2]);
endmodule
bind sync_serial_port ssp_checker ssp_checker_inst (.*);
`default_nettype wire

// ### dv/ssp_spi_slave_model.sv
// spi peripheral model: clock idles low, msb first
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_slave_model (
   input  wire logic        sclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        sdo_in,
   input  wire logic [4:0]  size_in,
   input  wire logic [15:0] reply_in,
   output var logic         sdi_out,
   output var logic [15:0]  got_out
);
   int left;
   initial begin
      sdi_out = 1'b0;
      got_out = 16'h0000;
   end
   always @(negedge cs_n_in) begin
      left = size_in;
      got_out = 16'h0000;
      sdi_out = reply_in[left-1];
   end
   always @(posedge sclk_in) if (!cs_n_in) got_out = {got_out[14:0], sdo_in};
   always @(negedge sclk_in) if (!cs_n_in && left > 1) begin
      left = left - 1;
      sdi_out = reply_in[left-1];
   end
   // a released line must not keep its last bit, so flip it
   always @(posedge cs_n_in) sdi_out = ~sdi_out;
endmodule
`default_nettype wire

// ### dv/test_sync_serial_port.sv
// testbench for the synchronous serial port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_sync_serial_port;
   import ssp_pkg::*;
   logic        mclk_in = 1'b0, reset_n_in = 1'b0, enable_in = 1'b1, master_mode_in = 1'b1;
   logic        sequential_in = 1'b0, tx_valid_in = 1'b0, rx_ready_in = 1'b0;
   logic        overrun_clear_in = 1'b0, sclk_in = 1'b0, chip_select_line_in = 1'b1;
   logic [1:0]  slaves_m1_in = 2'h0;
   logic [3:0]  profile_fsync_in = 4'h0;
   logic [15:0] profile_size_m1_in = 16'h7777, tx_data_in = 16'h0000, preply = 16'h0000;
   logic [7:0]  prescale_in = 8'h01, rate_in = 8'h01;
   logic [2:0]  irq_mask_in = 3'h7;
   logic [4:0]  psize = 5'd8;
   wire logic   tx_ready_out, rx_valid_out, combined_irq_out, sclk_out, sclk_oe_out, sdo_out;
   wire logic   sdi_in;
   wire logic [15:0] rx_data_out, pgot;
   wire logic [2:0]  irq_status_out;
   wire logic [3:0]  chip_select_line_out, chip_select_line_oe_out;
   int          n_fail = 0, cmp_count = 0, cycles = 0, sel1 = 0;
   logic [15:0] tw [3] = '{16'h00a5, 16'hfff9, 16'h8001};
   logic [15:0] rw [3] = '{16'h003c, 16'h0006, 16'h7ffe};
   logic [15:0] mk [3] = '{16'h00ff, 16'h000f, 16'hffff};
   logic [4:0]  sz [3] = '{5'd8, 5'd4, 5'd16};
   sync_serial_port sync_serial_port_inst (.*);
   ssp_spi_slave_model ssp_spi_slave_model_inst (.sclk_in(sclk_out),
      .cs_n_in(chip_select_line_out[0]), .sdo_in(sdo_out), .size_in(psize),
      .reply_in(preply), .sdi_out(sdi_in), .got_out(pgot));
   always #25 mclk_in = ~mclk_in;
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // leaves valid high so back-to-back pushes never retoggle it
   task automatic push(input logic [15:0] w);
      tx_data_in <= w;
      tx_valid_in <= 1'b1;
      @(posedge mclk_in);
      while (tx_ready_out !== 1'b1) @(posedge mclk_in);
   endtask
   task automatic pull(input logic [15:0] exp, input bit chk);
      while (rx_valid_out !== 1'b1) @(posedge mclk_in);
      if (chk) `CHK(rx_data_out, exp)
      rx_ready_in <= 1'b1;
      @(posedge mclk_in);
      rx_ready_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   always @(posedge mclk_in) if (chip_select_line_out == 4'hd) sel1++;
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      repeat (8) @(posedge mclk_in);
      `CHK({sclk_out, sclk_oe_out, chip_select_line_out, chip_select_line_oe_out}, 10'h0f0)
      `CHK(irq_status_out, 3'h0)
      reset_n_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      for (int i = 0; i < 3; i++) begin
         psize <= sz[i];
         preply <= rw[i];
         profile_size_m1_in <= {4{sz[i][3:0] - 4'h1}};
         @(posedge mclk_in);
         push(tw[i]);
         tx_valid_in <= 1'b0;
         pull(rw[i], 1'b1);
         `CHK(pgot, tw[i] & mk[i])
      end
      irq_mask_in <= 3'h0;
      repeat (3) @(posedge mclk_in);
      `CHK({irq_status_out, combined_irq_out}, 4'h3)
      irq_mask_in <= 3'h1;
      repeat (3) @(posedge mclk_in);
      `CHK({irq_status_out, combined_irq_out}, 4'h2)
      psize <= 5'd4;
      preply <= 16'h0005;
      profile_size_m1_in <= 16'h3333;
      for (int i = 0; i < 34; i++) push(16'h000a);
      tx_valid_in <= 1'b0;
      for (int i = 0; i < 2000 && irq_status_out[2] !== 1'b1; i++) @(posedge mclk_in);
      `CHK(irq_status_out[2:1], 2'h3)
      for (int i = 0; i < 33; i++) pull(16'h0005, 1'b1);
      repeat (3) @(posedge mclk_in);
      `CHK(irq_status_out[1], 1'b0)
      overrun_clear_in <= 1'b1;
      @(posedge mclk_in);
      overrun_clear_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      `CHK(irq_status_out, 3'h1)
      sequential_in <= 1'b1;
      slaves_m1_in <= 2'h1;
      push(16'h0009);
      push(16'h0006);
      tx_valid_in <= 1'b0;
      pull(16'h0005, 1'b1);
      pull(16'h0000, 1'b0);
      `CHK(sel1 > 0, 1'b1)
      sequential_in <= 1'b0;
      profile_fsync_in <= 4'h1;
      @(posedge mclk_in);
      push(16'h0003);
      tx_valid_in <= 1'b0;
      pull(16'h0000, 1'b0);
      master_mode_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      `CHK({sclk_oe_out, chip_select_line_oe_out}, 5'h00)
      summarize();
   end
endmodule
`default_nettype wire

// ### hw/ssp_pkg.sv
// constants for the synchronous serial port
package ssp_pkg;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_AW = 5;
   localparam int WORD_W = 16;
   localparam int SIZE_W = 4;
   localparam int NUM_SLAVES = 4;
   localparam logic [3:0] MIN_SIZE_M1 = 4'h3;
   localparam logic [7:0] PRESCALE_RESET = 8'h02;
   localparam logic [7:0] RATE_RESET = 8'h00;
   localparam int SLAVE_OS = 4;
   typedef enum logic {FMT_SPI, FMT_FSYNC} frame_fmt_e;
endpackage

// ### hw/sync_serial_port.sv
// synchronous serial port, master or slave, with 32x16 transmit and receive fifos
// Functional notes
// - master drives clock and selects, slave receives them, by configuration
// - master can serve up to four slaves in turn, sequential mode
// - transmit and receive each use a separate 32 by 16 fifo
// - frame length programmable from 4 to 16 bits
// - frames shift msb first, received first bit is msb
// - incoming serial bits are gathered into words for the receive fifo
// - software selects spi format or frame-sync format
// - format and word size come from per-slave settings; master or slave mode is global
// - frame-sync format: select output is active-high sync pulse
// - spi format: select output is active-low chip select
// - select and clock pins drive in master mode, inputs in slave mode
// - slave mode uses only the first select line
// - serial clock from engine clock via prescaler and rate divider
// - tx fifo, rx fifo and rx overrun sources each masked
// - one combined interrupt when any source active and unmasked
// - registers and rate divider share the one engine clock
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port
   import ssp_pkg::*;
(
   input  wire logic                         mclk_in,
   input  wire logic                         reset_n_in,
   input  wire logic                         enable_in,
   input  wire logic                         master_mode_in,
   input  wire logic                         sequential_in,
   input  wire logic [1:0]                   slaves_m1_in,
   input  wire logic [NUM_SLAVES-1:0]        profile_fsync_in,
   input  wire logic [NUM_SLAVES*SIZE_W-1:0] profile_size_m1_in,
   input  wire logic [7:0]                   prescale_in,
   input  wire logic [7:0]                   rate_in,
   input  wire logic [WORD_W-1:0]            tx_data_in,
   input  wire logic                         tx_valid_in,
   output logic                              tx_ready_out,
   output logic [WORD_W-1:0]                 rx_data_out,
   output logic                              rx_valid_out,
   input  wire logic                         rx_ready_in,
   input  wire logic [2:0]                   irq_mask_in,
   input  wire logic                         overrun_clear_in,
   output logic [2:0]                        irq_status_out,
   output logic                              combined_irq_out,
   output logic                              sclk_out,
   output logic                              sclk_oe_out,
   input  wire logic                         sclk_in,
   output logic [NUM_SLAVES-1:0]             chip_select_line_out,
   output logic [NUM_SLAVES-1:0]             chip_select_line_oe_out,
   input  wire logic                         chip_select_line_in,
   output logic                              sdo_out,
   input  wire logic                         sdi_in
);
   import ssp_pkg::*;

   typedef enum {ST_IDLE, ST_SHIFT, ST_SYNC} shift_state_e;

   // fifo storage, flip-flops addressed by index
   logic [WORD_W-1:0]  tx_mem_q [FIFO_DEPTH];
   logic [WORD_W-1:0]  rx_mem_q [FIFO_DEPTH];
   logic [FIFO_AW:0]   tx_wp_q;
   logic [FIFO_AW:0]   tx_rp_q;
   logic [FIFO_AW:0]   rx_wp_q;
   logic [FIFO_AW:0]   rx_rp_q;
   logic               overrun_q;
   logic [2:0]         irq_status_q;
   logic               combined_irq_q;

   // pin synchronisers; first stage read only by second
   logic [1:0]         sclk_sync_q;
   logic [1:0]         cs_sync_q;
   logic [1:0]         sdi_sync_q;
   logic               sclk_prev_q;

   shift_state_e       state_q;
   logic [7:0]         pre_cnt_q;
   logic [7:0]         rate_cnt_q;
   logic               sclk_q;
   logic               sclk_oe_q;
   logic [NUM_SLAVES-1:0] cs_q;
   logic [NUM_SLAVES-1:0] cs_oe_q;
   logic               sdo_q;
   logic               ending_q;
   logic [WORD_W-1:0]  tx_shift_q;
   logic [WORD_W-1:0]  rx_shift_q;
   logic [SIZE_W-1:0]  bit_cnt_q;
   logic [1:0]         slave_q;
   logic               fsync_q;
   logic [SIZE_W-1:0]  size_q;
   logic               tx_ready_q;
   logic               rx_valid_q;
   logic [WORD_W-1:0]  rx_data_q;

   function automatic logic [SIZE_W-1:0] profile_size(input logic [1:0] idx,
         input logic [NUM_SLAVES*SIZE_W-1:0] sizes);
      logic [SIZE_W-1:0] s;
      s = sizes[idx*SIZE_W +: SIZE_W];
      profile_size = (s < MIN_SIZE_M1) ? MIN_SIZE_M1 : s;
   endfunction

   wire               tx_empty   = (tx_wp_q == tx_rp_q);
   wire               tx_full    = (tx_wp_q[FIFO_AW-1:0] == tx_rp_q[FIFO_AW-1:0])
                                   && (tx_wp_q[FIFO_AW] != tx_rp_q[FIFO_AW]);
   wire               rx_empty   = (rx_wp_q == rx_rp_q);
   wire               rx_full    = (rx_wp_q[FIFO_AW-1:0] == rx_rp_q[FIFO_AW-1:0])
                                   && (rx_wp_q[FIFO_AW] != rx_rp_q[FIFO_AW]);
   wire               tx_push    = tx_valid_in && tx_ready_q;
   wire               rx_pop     = rx_valid_q && rx_ready_in;
   // a push into the last free slot drops ready a cycle early, never late
   wire               tx_fill_one = (tx_wp_q[FIFO_AW-1:0] + 5'h01 == tx_rp_q[FIFO_AW-1:0])
                                    && tx_push;

   // prescaler then rate divider make a one-cycle half-bit tick
   wire               pre_tick   = (pre_cnt_q == 8'h00);
   wire               half_tick  = pre_tick && (rate_cnt_q == 8'h00);

   // slave sampling: engine clock four times sclk, so edges are seen cleanly
   wire               s_rise     = sclk_sync_q[1] && !sclk_prev_q;
   wire               s_fall     = !sclk_sync_q[1] && sclk_prev_q;
   wire               s_sel      = !cs_sync_q[1];

   wire [1:0]         next_slave = (sequential_in && slave_q != slaves_m1_in)
                                   ? slave_q + 2'h1 : 2'h0;
   wire               last_bit   = (bit_cnt_q == size_q);
   wire               master_go  = enable_in && master_mode_in && !tx_empty;
   wire [WORD_W-1:0]  tx_head    = tx_mem_q[tx_rp_q[FIFO_AW-1:0]];
   wire [WORD_W-1:0]  tx_aligned = tx_head << (4'hf - profile_size(slave_q,
                                   profile_size_m1_in));
   wire [SIZE_W-1:0]  cur_size   = profile_size(slave_q, profile_size_m1_in);
   wire               cur_fsync  = profile_fsync_in[slave_q];
   // idle select level follows the profile, so a sync pulse rises from low
   wire               idle_fsync = master_mode_in ? cur_fsync : profile_fsync_in[0];
   wire [WORD_W-1:0]  rx_word    = {rx_shift_q[WORD_W-2:0], sclk_sync_q[1] ? sdi_sync_q[1]
                                   : sdi_sync_q[1]};
   logic              frame_done;
   logic              frame_bit;
   logic              tx_pop;
   logic [WORD_W-1:0] rx_push_word;

   // event decode shared by master and slave sampling
   always_comb begin
      frame_bit = 1'b0;
      if (state_q == ST_SHIFT) begin
         if (master_mode_in)
            frame_bit = half_tick && sclk_q == 1'b0 && sclk_oe_q;
         else
            frame_bit = s_rise && (s_sel || fsync_q);
      end
   end
   assign frame_done   = frame_bit && last_bit;
   assign rx_push_word = rx_word;
   assign tx_pop       = (state_q == ST_IDLE) && !tx_empty &&
                         ((master_go && half_tick) || (!master_mode_in && enable_in));

   // fifo writes: transmit write pointer, storage for both fifos
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_wp_q <= '0;
      end else if (tx_push) begin
         tx_wp_q <= tx_wp_q + 6'h01;
      end
   end
   always_ff @(posedge mclk_in) begin
      if (tx_push)
         tx_mem_q[tx_wp_q[FIFO_AW-1:0]] <= tx_data_in;
      if (frame_done && !rx_full)
         rx_mem_q[rx_wp_q[FIFO_AW-1:0]] <= rx_push_word;
   end

   // fifo pointers and handshake outputs
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_rp_q    <= '0;
         rx_wp_q    <= '0;
         rx_rp_q    <= '0;
         tx_ready_q <= 1'b0;
         rx_valid_q <= 1'b0;
         rx_data_q  <= '0;
      end else begin
         if (tx_pop)
            tx_rp_q <= tx_rp_q + 6'h01;
         if (frame_done && !rx_full)
            rx_wp_q <= rx_wp_q + 6'h01;
         tx_ready_q <= !(tx_full || tx_fill_one);
         if (rx_pop || !rx_valid_q) begin
            if (!rx_empty && !(rx_pop && !rx_valid_q)) begin
               rx_data_q  <= rx_mem_q[rx_rp_q[FIFO_AW-1:0]];
               rx_valid_q <= 1'b1;
               rx_rp_q    <= rx_rp_q + 6'h01;
            end else begin
               rx_valid_q <= 1'b0;
            end
         end
      end
   end

   // overrun flag: a new overrun wins over a clear in the same cycle
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         overrun_q      <= 1'b0;
         irq_status_q   <= 3'h0;
         combined_irq_q <= 1'b0;
      end else begin
         if (frame_done && rx_full)
            overrun_q <= 1'b1;
         else if (overrun_clear_in)
            overrun_q <= 1'b0;
         irq_status_q   <= {overrun_q, !rx_empty, tx_empty};
         combined_irq_q <= |(irq_status_q & ~irq_mask_in);
      end
   end

   // pin synchronisers
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sclk_sync_q <= 2'h0;
         cs_sync_q   <= 2'h3;
         sdi_sync_q  <= 2'h0;
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_sync_q <= {sclk_sync_q[0], sclk_in};
         cs_sync_q   <= {cs_sync_q[0], chip_select_line_in};
         sdi_sync_q  <= {sdi_sync_q[0], sdi_in};
         sclk_prev_q <= sclk_sync_q[1];
      end
   end

   // bit-rate divider on the engine clock; this block has a single clock
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pre_cnt_q  <= PRESCALE_RESET;
         rate_cnt_q <= RATE_RESET;
      end else if (pre_tick) begin
         pre_cnt_q <= prescale_in;
         rate_cnt_q <= (rate_cnt_q == 8'h00) ? rate_in : rate_cnt_q - 8'h01;
      end else begin
         pre_cnt_q <= pre_cnt_q - 8'h01;
      end
   end

   // shift engine; a half-bit tick gives at most half the engine rate
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q    <= ST_IDLE;
         sclk_q     <= 1'b0;
         sclk_oe_q  <= 1'b0;
         cs_q       <= '1;
         cs_oe_q    <= '0;
         sdo_q      <= 1'b0;
         tx_shift_q <= '0;
         rx_shift_q <= '0;
         bit_cnt_q  <= '0;
         slave_q    <= 2'h0;
         fsync_q    <= 1'b0;
         size_q     <= MIN_SIZE_M1;
         ending_q   <= 1'b0;
      end else begin
         sclk_oe_q <= enable_in && master_mode_in;
         cs_oe_q   <= {NUM_SLAVES{enable_in && master_mode_in}};
         unique case (state_q)
            ST_IDLE: begin
               sclk_q <= 1'b0;
               cs_q   <= idle_fsync ? '0 : '1;
               if (tx_pop) begin
                  size_q     <= cur_size;
                  fsync_q    <= master_mode_in ? cur_fsync : profile_fsync_in[0];
                  tx_shift_q <= tx_aligned;
                  sdo_q      <= tx_aligned[WORD_W-1];
                  bit_cnt_q  <= '0;
                  rx_shift_q <= '0;
                  if (master_mode_in && cur_fsync) begin
                     cs_q    <= '0;
                     cs_q[slave_q] <= 1'b1;
                     state_q <= ST_SYNC;
                  end else begin
                     cs_q    <= '1;
                     cs_q[slave_q] <= !master_mode_in || 1'b0;
                     state_q <= ST_SHIFT;
                  end
               end
            end
            ST_SYNC: begin
               // sync pulse lasts one bit, then data follows
               if (half_tick) begin
                  sclk_q <= !sclk_q;
                  if (sclk_q) begin
                     cs_q    <= '0;
                     state_q <= ST_SHIFT;
                  end
               end
            end
            ST_SHIFT: begin
               if (master_mode_in ? (half_tick && sclk_q) :
                   (s_fall && (s_sel || fsync_q))) begin
                  tx_shift_q <= {tx_shift_q[WORD_W-2:0], 1'b0};
                  sdo_q      <= tx_shift_q[WORD_W-2];
               end
               if (master_mode_in && half_tick)
                  sclk_q <= !sclk_q;
               if (frame_bit) begin
                  rx_shift_q <= rx_word;
                  bit_cnt_q  <= bit_cnt_q + 4'h1;
               end
               // master keeps the last clock high a full half bit before ending
               if (frame_done && master_mode_in)
                  ending_q <= 1'b1;
               if (frame_done && !master_mode_in) begin
                  cs_q    <= fsync_q ? '0 : '1;
                  state_q <= ST_IDLE;
               end
               if (ending_q && half_tick) begin
                  ending_q <= 1'b0;
                  sclk_q   <= 1'b0;
                  cs_q     <= fsync_q ? '0 : '1;
                  slave_q  <= next_slave;
                  state_q  <= ST_IDLE;
               end
               if (!enable_in) begin
                  ending_q <= 1'b0;
                  cs_q    <= '1;
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   assign tx_ready_out            = tx_ready_q;
   assign rx_data_out             = rx_data_q;
   assign rx_valid_out            = rx_valid_q;
   assign irq_status_out          = irq_status_q;
   assign combined_irq_out        = combined_irq_q;
   assign sclk_out                = sclk_q;
   assign sclk_oe_out             = sclk_oe_q;
   assign chip_select_line_out    = cs_q;
   assign chip_select_line_oe_out = cs_oe_q;
   assign sdo_out                 = sdo_q;
endmodule
`default_nettype wire
